/* hw/swm_master.sv */
`timescale 1ns/100ps
module swm_master #(
	parameter int P_STD_RESET_LOW = swm_pkg::STD_RESET_LOW_CYC,
	parameter int P_STD_PRESENCE_SAMPLE = swm_pkg::STD_PRESENCE_SAMPLE_CYC,
	parameter int P_STD_RESET_HIGH = swm_pkg::STD_RESET_HIGH_CYC,
	parameter int P_STD_WRITE_ZERO_LOW = swm_pkg::STD_WRITE_ZERO_LOW_CYC,
	parameter int P_STD_WRITE_ONE_LOW = swm_pkg::STD_WRITE_ONE_LOW_CYC,
	parameter int P_STD_READ_SAMPLE = swm_pkg::STD_READ_SAMPLE_CYC,
	parameter int P_STD_SLOT = swm_pkg::STD_SLOT_CYC,
	parameter int P_FST_RESET_LOW = swm_pkg::FST_RESET_LOW_CYC,
	parameter int P_FST_PRESENCE_SAMPLE = swm_pkg::FST_PRESENCE_SAMPLE_CYC,
	parameter int P_FST_RESET_HIGH = swm_pkg::FST_RESET_HIGH_CYC,
	parameter int P_FST_WRITE_ZERO_LOW = swm_pkg::FST_WRITE_ZERO_LOW_CYC,
	parameter int P_FST_WRITE_ONE_LOW = swm_pkg::FST_WRITE_ONE_LOW_CYC,
	parameter int P_FST_READ_SAMPLE = swm_pkg::FST_READ_SAMPLE_CYC,
	parameter int P_FST_SLOT = swm_pkg::FST_SLOT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_long_reset,
	// answer
	output logic done,
	output logic [7:0] rd_data,
	output logic presence,
	output logic fast_speed_flag,
	// crc checking
	input wire logic crc_clear,
	output logic [7:0] crc8,
	output logic [15:0] crc16,
	// bus line, open drain
	input wire logic line_in,
	output logic line_out,
	output logic line_oe
);

	localparam int CW = swm_pkg::CNT_W;

	typedef struct packed {
		swm_pkg::swm_state_t st;
		logic [CW-1:0] cnt;
		logic [2:0] bit_idx;
		logic byte_mode;
		logic [7:0] sh;
		logic [7:0] rx;
		// rx fills during slots, rd only moves at the end of a command
		logic [7:0] rd;
		logic fast;
		logic first;
		logic set_fast;
		logic long_rst;
		logic presence;
		logic done;
		logic drive;
	} swm_regs_t;

	localparam swm_regs_t REGS_RESET = '{
		st: swm_pkg::ST_IDLE,
		cnt: '0,
		bit_idx: 3'h0,
		byte_mode: 1'b0,
		sh: 8'h00,
		rx: 8'h00,
		rd: 8'h00,
		fast: 1'b0,
		first: 1'b0,
		set_fast: 1'b0,
		long_rst: 1'b0,
		presence: 1'b0,
		done: 1'b0,
		drive: 1'b0
	};

	swm_regs_t q;
	swm_regs_t d;

	// speed-selected end counts, last cycle index of each phase
	logic [CW-1:0] end_rst_low;
	logic [CW-1:0] end_pres_sample;
	logic [CW-1:0] end_rst_high;
	logic [CW-1:0] end_zero_low;
	logic [CW-1:0] end_one_low;
	logic [CW-1:0] end_sample;
	logic [CW-1:0] end_slot;
	logic [CW-1:0] end_low;
	logic sample_now;
	logic in_slot;

	always_comb
	begin
		// every waveform follows the current speed, except the low phase of a long reset
		if (q.fast)
		begin
			end_rst_low = CW'(P_FST_RESET_LOW - 1);
			end_pres_sample = CW'(P_FST_PRESENCE_SAMPLE - 1);
			end_rst_high = CW'(P_FST_RESET_HIGH - 1);
			end_zero_low = CW'(P_FST_WRITE_ZERO_LOW - 1);
			end_one_low = CW'(P_FST_WRITE_ONE_LOW - 1);
			end_sample = CW'(P_FST_READ_SAMPLE - 1);
			end_slot = CW'(P_FST_SLOT - 1);
		end
		else
		begin
			end_rst_low = CW'(P_STD_RESET_LOW - 1);
			end_pres_sample = CW'(P_STD_PRESENCE_SAMPLE - 1);
			end_rst_high = CW'(P_STD_RESET_HIGH - 1);
			end_zero_low = CW'(P_STD_WRITE_ZERO_LOW - 1);
			end_one_low = CW'(P_STD_WRITE_ONE_LOW - 1);
			end_sample = CW'(P_STD_READ_SAMPLE - 1);
			end_slot = CW'(P_STD_SLOT - 1);
		end
		// a long reset always runs at standard length
		if (q.long_rst)
			end_rst_low = CW'(P_STD_RESET_LOW - 1);
	end

	// a read slot is a write-one slot; the line shows the slave's answer
	assign end_low = q.sh[0] ? end_one_low : end_zero_low;
	assign in_slot = (q.st == swm_pkg::ST_SLOT_LOW) || (q.st == swm_pkg::ST_SLOT_REST);
	assign sample_now = in_slot && (q.cnt == end_sample);

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		unique case (q.st)
			swm_pkg::ST_IDLE:
			begin
				d.cnt = '0;
				if (cmd_valid)
				begin
					unique case (cmd_op)
						swm_pkg::OP_RESET:
						begin
							// short reset while fast keeps the speed
							d.long_rst = cmd_long_reset | ~q.fast;
							d.drive = 1'b1;
							d.st = swm_pkg::ST_RST_LOW;
						end
						swm_pkg::OP_BYTE:
						begin
							d.byte_mode = 1'b1;
							d.bit_idx = 3'h0;
							d.sh = cmd_data;
							// first rom byte after reset may switch speed
							// no collision guard: keep reads off a shared bus after fast skip
							d.set_fast = q.first &&
								(cmd_data == swm_pkg::ROM_FAST_SKIP ||
								cmd_data == swm_pkg::ROM_FAST_MATCH);
							d.drive = 1'b1;
							d.st = swm_pkg::ST_SLOT_LOW;
						end
						swm_pkg::OP_BIT:
						begin
							d.byte_mode = 1'b0;
							d.bit_idx = 3'h0;
							d.sh = {7'h00, cmd_data[0]};
							d.set_fast = 1'b0;
							d.drive = 1'b1;
							d.st = swm_pkg::ST_SLOT_LOW;
						end
						default:
						begin
							// unknown op: answered at once, line untouched
							d.done = 1'b1;
						end
					endcase
				end
			end
			swm_pkg::ST_RST_LOW:
			begin
				d.cnt = q.cnt + 1'b1;
				// rounding up to whole cycles is exact at 4 ns, so nothing is added for a slow fall
				if (q.cnt == end_rst_low)
				begin
					d.drive = 1'b0;
					d.cnt = '0;
					d.st = swm_pkg::ST_RST_WAIT;
					if (q.long_rst)
						d.fast = 1'b0;
				end
			end
			swm_pkg::ST_RST_WAIT:
			begin
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == end_pres_sample)
					d.presence = ~line_in;
				if (q.cnt == end_rst_high)
				begin
					// window covers presence and recovery
					d.cnt = '0;
					d.first = 1'b1;
					d.long_rst = 1'b0;
					d.done = 1'b1;
					d.st = swm_pkg::ST_IDLE;
				end
			end
			swm_pkg::ST_SLOT_LOW:
			begin
				d.cnt = q.cnt + 1'b1;
				// fast low periods stay far below 15us
				if (q.cnt == end_low)
				begin
					d.drive = 1'b0;
					d.st = swm_pkg::ST_SLOT_REST;
				end
			end
			swm_pkg::ST_SLOT_REST:
			begin
				d.cnt = q.cnt + 1'b1;
				// full slot elapses, giving the slave its recovery
				if (q.cnt == end_slot)
				begin
					d.cnt = '0;
					if (q.byte_mode && q.bit_idx != 3'h7)
					begin
						d.bit_idx = q.bit_idx + 3'h1;
						d.sh = {1'b0, q.sh[7:1]};
						d.drive = 1'b1;
						d.st = swm_pkg::ST_SLOT_LOW;
					end
					else
					begin
						// once fast, only a long reset clears it
						if (q.set_fast)
							d.fast = 1'b1;
						d.set_fast = 1'b0;
						d.first = 1'b0;
						d.rd = q.rx;
						d.done = 1'b1;
						d.st = swm_pkg::ST_IDLE;
					end
				end
			end
			default:
			begin
				d = REGS_RESET;
			end
		endcase

		// either slot state: a written zero still holds the line low at the sample
		if (sample_now)
		begin
			// late sample inside the read window
			if (q.byte_mode)
				d.rx = {line_in, q.rx[7:1]};
			else
				d.rx = {7'h00, line_in};
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			q <= REGS_RESET;
		else if (ce)
			q <= d;
	end

	// every bus bit, written or read back, feeds both checkers lsb first
	swm_crc #(
		.W(8),
		.POLY(swm_pkg::CRC8_POLY),
		.INIT(swm_pkg::CRC8_INIT)
	) u_crc8 (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.clear(crc_clear),
		.bit_valid(sample_now),
		.bit_in(line_in),
		.crc(crc8)
	);

	swm_crc #(
		.W(16),
		.POLY(swm_pkg::CRC16_POLY),
		.INIT(swm_pkg::CRC16_INIT)
	) u_crc16 (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.clear(crc_clear),
		.bit_valid(sample_now),
		.bit_in(line_in),
		.crc(crc16)
	);

	assign cmd_ready = (q.st == swm_pkg::ST_IDLE);
	assign done = q.done;
	assign rd_data = q.rd;
	assign presence = q.presence;
	assign fast_speed_flag = q.fast;
	// open drain: only ever pulls low
	assign line_out = 1'b0;
	assign line_oe = q.drive;

endmodule

/* hw/swm_pkg.sv */
// What this block does
// - Once fast, all slots use fast timing until a long reset.
// - After fast skip on multidrop, master sends fast reset then match or search.
// - Master avoids read commands after fast skip with several fast slaves; the block has no guard, the user keeps reads off.
// - A slewed falling edge lengthens reset low by the fall time; the block counts a fixed reset low and adds no fall time.
// - Master samples at presence sample time; low means slave present.
// - Reset high window covers presence plus recovery; data slots follow at once.
// - On mixed buses stretch reset high window to 480us or 48us.
// - Each slot carries one bit and starts with master pulling low.
// - One: release before write-one low time; zero: hold past write-zero time.
// - After each slot the line rests high for the recovery time.
// - Read slot: master pulls low briefly; slave holds low to return zero.
// - Master samples inside read window, late, and waits full slot time.
// - ROM check: CRC-8, x^8+x^5+x^4+1 over 56 bits versus stored byte.
// - Bus idles high; fast-speed slot low periods stay at or under 15us.
package swm_pkg;

	localparam int CLK_PERIOD_NS = 4;
	localparam int CNT_W = 18;

	function automatic int cyc_up(input int ns);
		return ((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
			(ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	function automatic int cyc_dn(input int ns);
		return (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
	endfunction

	// standard speed times, ns
	localparam int STD_RESET_LOW_NS = 480000;
	localparam int STD_PRESENCE_SAMPLE_NS = 70000;
	localparam int STD_RESET_HIGH_NS = 480000;
	localparam int STD_WRITE_ZERO_LOW_NS = 60000;
	localparam int STD_WRITE_ONE_LOW_NS = 6000;
	localparam int STD_READ_SAMPLE_NS = 13000;
	localparam int STD_SLOT_NS = 70000;
	// fast speed times, ns; reset low sits between 48us and 80us
	localparam int FST_RESET_LOW_NS = 56000;
	localparam int FST_PRESENCE_SAMPLE_NS = 8500;
	localparam int FST_RESET_HIGH_NS = 48000;
	localparam int FST_WRITE_ZERO_LOW_NS = 8000;
	localparam int FST_WRITE_ONE_LOW_NS = 1000;
	localparam int FST_READ_SAMPLE_NS = 2000;
	localparam int FST_SLOT_NS = 10000;

	// cycle counts: least times round up, sample points round down
	localparam int STD_RESET_LOW_CYC = cyc_up(STD_RESET_LOW_NS);
	localparam int STD_PRESENCE_SAMPLE_CYC = cyc_dn(STD_PRESENCE_SAMPLE_NS);
	localparam int STD_RESET_HIGH_CYC = cyc_up(STD_RESET_HIGH_NS);
	localparam int STD_WRITE_ZERO_LOW_CYC = cyc_up(STD_WRITE_ZERO_LOW_NS);
	localparam int STD_WRITE_ONE_LOW_CYC = cyc_up(STD_WRITE_ONE_LOW_NS);
	localparam int STD_READ_SAMPLE_CYC = cyc_dn(STD_READ_SAMPLE_NS);
	localparam int STD_SLOT_CYC = cyc_up(STD_SLOT_NS);
	localparam int FST_RESET_LOW_CYC = cyc_up(FST_RESET_LOW_NS);
	localparam int FST_PRESENCE_SAMPLE_CYC = cyc_dn(FST_PRESENCE_SAMPLE_NS);
	localparam int FST_RESET_HIGH_CYC = cyc_up(FST_RESET_HIGH_NS);
	localparam int FST_WRITE_ZERO_LOW_CYC = cyc_up(FST_WRITE_ZERO_LOW_NS);
	localparam int FST_WRITE_ONE_LOW_CYC = cyc_up(FST_WRITE_ONE_LOW_NS);
	localparam int FST_READ_SAMPLE_CYC = cyc_dn(FST_READ_SAMPLE_NS);
	localparam int FST_SLOT_CYC = cyc_up(FST_SLOT_NS);

	// rom commands that switch speed
	localparam logic [7:0] ROM_FAST_SKIP = 8'h3C;
	localparam logic [7:0] ROM_FAST_MATCH = 8'h69;

	// reflected polynomials, shifted lsb first
	localparam logic [7:0] CRC8_POLY = 8'h8C;
	localparam logic [15:0] CRC16_POLY = 16'hA001;
	localparam logic [7:0] CRC8_INIT = 8'h00;
	localparam logic [15:0] CRC16_INIT = 16'h0000;

	typedef enum logic [1:0] {
		OP_RESET = 2'h0,
		OP_BYTE = 2'h1,
		OP_BIT = 2'h2
	} swm_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RST_LOW = 3'h1,
		ST_RST_WAIT = 3'h2,
		ST_SLOT_LOW = 3'h3,
		ST_SLOT_REST = 3'h4
	} swm_state_t;

endpackage

/* hw/swm_crc.sv */
`timescale 1ns/100ps
module swm_crc #(
	parameter int W = 8,
	parameter logic [W-1:0] POLY = '0,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// control
	input wire logic clear,
	input wire logic bit_valid,
	input wire logic bit_in,
	// result
	output logic [W-1:0] crc
);

	typedef struct packed {
		logic [W-1:0] crc;
	} swm_crc_regs_t;

	swm_crc_regs_t q;
	swm_crc_regs_t d;

	always_comb
	begin
		d = q;
		// clear first, so a bit in the same cycle starts a fresh sum
		if (clear)
			d.crc = INIT;
		if (bit_valid)
		begin
			if (d.crc[0] ^ bit_in)
				d.crc = (d.crc >> 1) ^ POLY;
			else
				d.crc = d.crc >> 1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			q <= '{crc: INIT};
		else if (ce)
			q <= d;
	end

	assign crc = q.crc;

endmodule

/* testbench/swm_master_asserts.sv */
`timescale 1ns/100ps
module swm_master_asserts #(
	parameter int P_FST_WRITE_ONE_LOW = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// command side
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic done,
	input wire logic [7:0] rd_data,
	input wire logic presence,
	input wire logic fast_speed_flag,
	// bus
	input wire logic line_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [17:0] lo_q;
	always_ff @(posedge clk)
		lo_q <= (reset || !line_oe) ? 18'h0 : lo_q + 18'h1;
	sequence s_take;
		ce && cmd_valid && cmd_ready && cmd_op != 2'h3;
	endsequence
	AST_START: assert property (s_take |-> ##[1:2] line_oe)
		else $error("no low after take");
	AST_IDLE: assert property (cmd_ready |-> !line_oe)
		else $error("idle line pulled");
	AST_LOW_MIN: assert property ($fell(line_oe) |-> lo_q >= P_FST_WRITE_ONE_LOW)
		else $error("low pulse too short");
	AST_READY: assert property (done |-> cmd_ready)
		else $error("not ready at done");
	AST_FALL: assert property ($fell(fast_speed_flag) |-> !line_oe)
		else $error("speed dropped in slot");
	AST_RISE: assert property ($rose(fast_speed_flag) |-> done || $past(done))
		else $error("speed rose off a byte end");
	AST_RD: assert property ($changed(rd_data) |-> done)
		else $error("read data moved without done");
	AST_PRES: assert property ($changed(presence) |-> !line_oe && !cmd_ready)
		else $error("presence moved outside wait");
endmodule
bind swm_master swm_master_asserts #(.P_FST_WRITE_ONE_LOW(P_FST_WRITE_ONE_LOW)) u_chk (
	.clk(clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.cmd_op(cmd_op), .done(done), .rd_data(rd_data), .presence(presence),
	.fast_speed_flag(fast_speed_flag), .line_oe(line_oe)
);

/* testbench/swm_dev_model.sv */
`timescale 1ns/100ps
module swm_dev_model (
	// bus
	input wire logic clk,
	input wire logic line,
	input wire logic [7:0] resp,
	// state
	output logic pull,
	output logic fast
);
	int lo = 0;
	int pres = 0;
	int hold = 0;
	int nb = 0;
	logic prev = 1'h1;
	logic first = 1'h0;
	logic [7:0] rx = 8'h00;
	initial pull = 1'h0;
	initial fast = 1'h0;
	always @(posedge clk)
	begin
		if (!line)
			lo++;
		if (pres > 0)
		begin
			pres--;
			lo = 0;
			// release as the count ends, so the presence end is not read as a slot
			pull <= pres > 0 && pres < (fast ? 30 : 60); // wait, then pull
		end
		else
		begin
			if (prev && !line && hold == 0 && !resp[nb]) // timer from the fall
				hold = fast ? 12 : 20; // zero answer
			else if (hold > 0)
				hold--;
			pull <= hold > 0;
			if (!prev && line && lo > 0)
			begin
				if (lo >= (fast ? 80 : 180)) // reset at either speed
				begin
					if (lo >= 180)
						fast = 1'h0; // long reset
					pres = fast ? 34 : 75;
					first = 1'h1;
					nb = 0;
				end
				else
				begin
					rx = {lo < (fast ? 10 : 20), rx[7:1]}; // lsb first
					nb = (nb + 1) % 8;
					if (nb == 0 && first && (rx == 8'h3C || rx == 8'h69))
						fast = 1'h1; // never cleared by a miss
					if (nb == 0)
						first = 1'h0; // only the first byte is a rom command
				end
				lo = 0;
			end
		end
		prev = line;
	end
endmodule

/* testbench/test_swm_master.sv */
`timescale 1ns/100ps
`define CHK(a, b) \
	begin \
		cmp_count++; \
		if ((a) !== (b)) \
		begin \
			fails++; \
			$display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); \
		end \
	end
module test_swm_master;
	localparam int SRL = 200;
	localparam int SRH = 200;
	localparam int SSL = 50;
	localparam int FRL = 100;
	localparam int FRH = 100;
	localparam int FSL = 25;
	localparam int SPS = 60;
	localparam int SW0 = 40;
	localparam int SW1 = 5;
	localparam int SRS = 10;
	localparam int FPS = 30;
	localparam int FW0 = 20;
	localparam int FW1 = 3;
	localparam int FRS = 6;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic cmd_valid = 1'h0;
	logic [1:0] cmd_op = 2'h0;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_long_reset = 1'h0;
	logic crc_clear = 1'h0;
	logic [7:0] resp = 8'hFF;
	logic ce = 1'h1;
	logic cmd_ready, done, presence, fast_speed_flag, line_oe, line_out, pull, dev_fast;
	logic [7:0] rd_data, crc8;
	logic [15:0] crc16;
	wire line;
	int fails = 0;
	int cmp_count = 0;
	int n;
	// pull-up: released line reads high
	assign line = !((line_oe && !line_out) | pull);
	always #2 clk = ~clk;
	swm_master #(
		.P_STD_RESET_LOW(SRL), .P_STD_PRESENCE_SAMPLE(SPS), .P_STD_RESET_HIGH(SRH),
		.P_STD_WRITE_ZERO_LOW(SW0), .P_STD_WRITE_ONE_LOW(SW1), .P_STD_READ_SAMPLE(SRS),
		.P_STD_SLOT(SSL), .P_FST_RESET_LOW(FRL), .P_FST_PRESENCE_SAMPLE(FPS),
		.P_FST_RESET_HIGH(FRH), .P_FST_WRITE_ZERO_LOW(FW0), .P_FST_WRITE_ONE_LOW(FW1),
		.P_FST_READ_SAMPLE(FRS), .P_FST_SLOT(FSL)
	) u_dut (
		.clk(clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_long_reset(cmd_long_reset), .done(done),
		.rd_data(rd_data), .presence(presence), .fast_speed_flag(fast_speed_flag),
		.crc_clear(crc_clear), .crc8(crc8), .crc16(crc16), .line_in(line), .line_out(line_out),
		.line_oe(line_oe)
	);
	swm_dev_model u_dev (.clk(clk), .line(line), .resp(resp), .pull(pull), .fast(dev_fast));
	function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b, logic [15:0] p);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? (c >> 1) ^ p : c >> 1;
		return c;
	endfunction
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic do_cmd(logic [1:0] op, logic [7:0] d, logic lr, logic [7:0] r);
		@(negedge clk);
		{cmd_op, cmd_data, cmd_long_reset, resp} = {op, d, lr, r};
		cmd_valid = 1'h1;
		@(negedge clk);
		cmd_valid = 1'h0;
		wait_done();
	endtask
	task automatic wait_done();
		for (n = 0; n < 5000 && done !== 1'h1; n++)
			@(negedge clk);
		if (n == 5000)
		begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic t_std();
		do_cmd(2'h0, 8'h00, 1'h0, 8'hFF);
		`CHK(n, SRL + SRH)
		`CHK(presence, 1'h1)
		`CHK(fast_speed_flag, 1'h0)
		do_cmd(2'h1, 8'hC3, 1'h0, 8'hFF);
		`CHK(n, 8 * SSL)
		`CHK(u_dev.rx, 8'hC3)
		do_cmd(2'h1, 8'hFF, 1'h0, 8'h5A);
		`CHK(rd_data, 8'h5A)
		$display("test std done");
	endtask
	task automatic t_crc();
		logic [63:0] rom;
		logic [15:0] c;
		rom = 64'h00A1B2C3D4E5F628;
		c = 16'h0000;
		for (int i = 0; i < 7; i++)
			c = crc_upd(c, rom[8*i +: 8], 16'h008C);
		rom[63:56] = c[7:0];
		c = 16'h0000;
		@(negedge clk);
		crc_clear = 1'h1;
		@(negedge clk);
		crc_clear = 1'h0;
		for (int i = 0; i < 8; i++)
		begin
			do_cmd(2'h1, 8'hFF, 1'h0, rom[8*i +: 8]);
			c = crc_upd(c, rom[8*i +: 8], 16'hA001);
		end
		`CHK(crc8, 8'h00)
		do_cmd(2'h1, 8'hFF, 1'h0, ~c[7:0]);
		do_cmd(2'h1, 8'hFF, 1'h0, ~c[15:8]);
		`CHK(crc16, 16'hB001)
		$display("test crc done");
	endtask
	task automatic t_fast();
		do_cmd(2'h0, 8'h00, 1'h0, 8'hFF);
		do_cmd(2'h1, 8'h3C, 1'h0, 8'hFF);
		`CHK(fast_speed_flag, 1'h1)
		do_cmd(2'h1, 8'hFF, 1'h0, 8'hA5);
		`CHK(n, 8 * FSL)
		`CHK(rd_data, 8'hA5)
		do_cmd(2'h0, 8'h00, 1'h0, 8'hFF);
		`CHK(n, FRL + FRH)
		`CHK(presence, 1'h1)
		do_cmd(2'h1, 8'h69, 1'h0, 8'hFF);
		`CHK(fast_speed_flag, 1'h1)
		do_cmd(2'h0, 8'h00, 1'h1, 8'hFF);
		`CHK(fast_speed_flag, 1'h0)
		`CHK(dev_fast, 1'h0)
		$display("test fast done");
	endtask
	task automatic t_match();
		do_cmd(2'h1, 8'h69, 1'h0, 8'hFF);
		`CHK(fast_speed_flag, 1'h1)
		do_cmd(2'h2, 8'h01, 1'h0, 8'hFE);
		`CHK(n, FSL)
		`CHK(rd_data, 8'h00)
		$display("test match done");
	endtask
	task automatic t_ce();
		do_cmd(2'h3, 8'h00, 1'h0, 8'hFF);
		`CHK(n, 0)
		@(negedge clk);
		{cmd_op, cmd_data, resp} = {2'h2, 8'h01, 8'hFF};
		{ce, cmd_valid} = 2'b01;
		repeat (4) @(negedge clk);
		`CHK(cmd_ready, 1'h1)
		`CHK(line_oe, 1'h0)
		ce = 1'h1;
		@(negedge clk);
		cmd_valid = 1'h0;
		repeat (12) @(negedge clk);
		ce = 1'h0;
		repeat (10) @(negedge clk);
		`CHK(line_oe, 1'h0)
		ce = 1'h1;
		wait_done();
		`CHK(n, FSL - 12)
		`CHK(rd_data, 8'h01)
		$display("test ce done");
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		reset = 1'h0;
		t_std();
		t_crc();
		t_fast();
		t_match();
		t_ce();
		wrap_up();
	end
endmodule
